//--- two_speed_clock_startup.sv
// Two-speed start-up sequencer with AXI4-Lite registers
//
// Decided for this implementation: the AXI4-Lite register port and the address map.
`timescale 1ns/1ns
`include "two_speed_clock_startup_regs.svh"

module two_speed_clock_startup
  import two_speed_clock_startup_pkg::*;
#(
  parameter int SETTLE_CYCLES = `SETTLE_CYCLES
) (
  // Clock and reset
  input  wire logic                    ref_clk_i,
  input  wire logic                    rst_n_i,
  // Oscillator levels, sampled on ref_clk_i
  input  wire logic                    intosc_i,
  input  wire logic                    xtal_i,
  // Configuration word and wake event
  input  wire logic [`SRC_SEL_W-1:0]   osc_source_select_i,
  input  wire logic                    wake_i,
  // Clock outputs
  output logic                         sys_clk_o,
  output logic [`FREQ_SEL_W-1:0]       internal_freq_select_o,
  // Register bus
  input  wire axi_req_s                axi_req_i,
  output axi_rsp_s                     axi_rsp_o,
  // Interrupt
  output logic                         irq_o
);

  localparam int CNT_W = $clog2(SETTLE_CYCLES);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(SETTLE_CYCLES - 1);

  function automatic logic is_crystal(input logic [`SRC_SEL_W-1:0] src);
    return (src == `SRC_LOW_POWER) || (src == `SRC_CRYSTAL) || (src == `SRC_HIGH_SPEED);
  endfunction

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  seq_state_e        state_q, state_d;
  logic [CNT_W-1:0]  count_q, count_d;
  logic              settle_q, settle_d;
  logic              sys_clk_q, sys_clk_d;
  logic              intosc_q, xtal_q;
  logic              ev_settle, ev_switch;
  logic              int_fall, xtal_rise, xtal_fall;

  assign int_fall  = intosc_q & ~intosc_i;
  assign xtal_rise = ~xtal_q & xtal_i;
  assign xtal_fall = xtal_q & ~xtal_i;

  always_comb begin
    state_d   = state_q;
    count_d   = count_q;
    settle_d  = settle_q;
    sys_clk_d = intosc_i;
    ev_settle = 1'b0;
    ev_switch = 1'b0;
    if (wake_i) begin
      state_d  = ST_INT_COUNT;
      count_d  = '0;
      settle_d = 1'b0;
    end else begin
      unique case (state_q)
        ST_INT_COUNT: begin
          // Non-crystal sources never leave the internal oscillator
          if (is_crystal(osc_source_select_i) && xtal_rise) begin
            if (count_q == CNT_LAST) begin
              state_d = ST_INT_WAIT;
            end else begin
              count_d = count_q + 1'b1;
            end
          end
        end
        ST_INT_WAIT: begin
          if (int_fall) begin
            state_d   = ST_HOLD_LOW;
            settle_d  = 1'b1;
            ev_settle = 1'b1;
            sys_clk_d = 1'b0;
          end
        end
        ST_HOLD_LOW: begin
          sys_clk_d = 1'b0;
          if (xtal_fall) begin
            state_d   = ST_EXTERNAL;
            ev_switch = 1'b1;
          end
        end
        ST_EXTERNAL: begin
          sys_clk_d = xtal_i;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q   <= ST_INT_COUNT;
      count_q   <= '0;
      settle_q  <= 1'b0;
      sys_clk_q <= 1'b0;
      intosc_q  <= 1'b0;
      xtal_q    <= 1'b0;
    end else begin
      state_q   <= state_d;
      count_q   <= count_d;
      settle_q  <= settle_d;
      sys_clk_q <= sys_clk_d;
      intosc_q  <= intosc_i;
      xtal_q    <= xtal_i;
    end
  end

  assign sys_clk_o = sys_clk_q;

  // ----------------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------------
  logic                   aw_got_q, aw_got_d, w_got_q, w_got_d;
  logic [7:0]             waddr_q, waddr_d;
  logic [31:0]            wdata_q, wdata_d;
  logic                   wstb_q, wstb_d;
  logic                   bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [1:0]             bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0]            rdata_q, rdata_d;
  logic [`FREQ_SEL_W-1:0] freq_q, freq_d;
  logic [`IRQ_W-1:0]      irq_stat_q, irq_stat_d, irq_mask_q, irq_mask_d;
  logic                   irq_q, irq_d;
  logic                   aw_take, w_take, ar_take;

  assign aw_take = axi_req_i.awvalid & ~aw_got_q & ~bvalid_q;
  assign w_take  = axi_req_i.wvalid & ~w_got_q & ~bvalid_q;
  assign ar_take = axi_req_i.arvalid & ~rvalid_q;

  always_comb begin
    aw_got_d   = aw_got_q | aw_take;
    w_got_d    = w_got_q | w_take;
    waddr_d    = aw_take ? axi_req_i.awaddr[7:0] : waddr_q;
    wdata_d    = w_take ? axi_req_i.wdata : wdata_q;
    wstb_d     = w_take ? axi_req_i.wstrb[0] : wstb_q;
    bvalid_d   = bvalid_q & ~axi_req_i.bready;
    bresp_d    = bresp_q;
    rvalid_d   = rvalid_q & ~axi_req_i.rready;
    rresp_d    = rresp_q;
    rdata_d    = rdata_q;
    freq_d     = freq_q;
    irq_mask_d = irq_mask_q;
    irq_stat_d = irq_stat_q;
    if (aw_got_q && w_got_q) begin
      aw_got_d = 1'b0;
      w_got_d  = 1'b0;
      bvalid_d = 1'b1;
      bresp_d  = `RESP_OKAY;
      unique case (waddr_q)
        `OFF_OSC_CONTROL: if (wstb_q) freq_d = wdata_q[`FREQ_SEL_W-1:0];
        `OFF_OSC_STATUS:  bresp_d = `RESP_OKAY;
        `OFF_IRQ_STATUS:  if (wstb_q) irq_stat_d = irq_stat_q & ~wdata_q[`IRQ_W-1:0];
        `OFF_IRQ_MASK:    if (wstb_q) irq_mask_d = wdata_q[`IRQ_W-1:0];
        default:          bresp_d = `RESP_SLVERR;
      endcase
    end
    // Set after clear, so an event in the clearing cycle survives
    if (ev_settle) irq_stat_d[`IRQ_SETTLE_BIT] = 1'b1;
    if (ev_switch) irq_stat_d[`IRQ_SWITCH_BIT] = 1'b1;
    if (ar_take) begin
      rvalid_d = 1'b1;
      rresp_d  = `RESP_OKAY;
      rdata_d  = '0;
      unique case (axi_req_i.araddr[7:0])
        `OFF_OSC_CONTROL: rdata_d[`FREQ_SEL_W-1:0] = freq_q;
        `OFF_OSC_STATUS: begin
          rdata_d[`STAT_SETTLE_BIT]   = settle_q;
          rdata_d[`STAT_EXT_BIT]      = (state_q == ST_EXTERNAL);
          rdata_d[`STAT_XTAL_CFG_BIT] = is_crystal(osc_source_select_i);
        end
        `OFF_IRQ_STATUS:  rdata_d[`IRQ_W-1:0] = irq_stat_q;
        `OFF_IRQ_MASK:    rdata_d[`IRQ_W-1:0] = irq_mask_q;
        default:          rresp_d = `RESP_SLVERR;
      endcase
    end
    irq_d = |(irq_stat_d & irq_mask_d);
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      aw_got_q   <= 1'b0;
      w_got_q    <= 1'b0;
      waddr_q    <= '0;
      wdata_q    <= '0;
      wstb_q     <= 1'b0;
      bvalid_q   <= 1'b0;
      bresp_q    <= `RESP_OKAY;
      rvalid_q   <= 1'b0;
      rresp_q    <= `RESP_OKAY;
      rdata_q    <= '0;
      freq_q     <= `FREQ_SEL_RST;
      irq_stat_q <= '0;
      irq_mask_q <= `IRQ_MASK_RST;
      irq_q      <= 1'b0;
    end else begin
      aw_got_q   <= aw_got_d;
      w_got_q    <= w_got_d;
      waddr_q    <= waddr_d;
      wdata_q    <= wdata_d;
      wstb_q     <= wstb_d;
      bvalid_q   <= bvalid_d;
      bresp_q    <= bresp_d;
      rvalid_q   <= rvalid_d;
      rresp_q    <= rresp_d;
      rdata_q    <= rdata_d;
      freq_q     <= freq_d;
      irq_stat_q <= irq_stat_d;
      irq_mask_q <= irq_mask_d;
      irq_q      <= irq_d;
    end
  end

  assign internal_freq_select_o = freq_q;
  assign irq_o                  = irq_q;
  assign axi_rsp_o.awready      = ~aw_got_q & ~bvalid_q;
  assign axi_rsp_o.wready       = ~w_got_q & ~bvalid_q;
  assign axi_rsp_o.bvalid       = bvalid_q;
  assign axi_rsp_o.bresp        = bresp_q;
  assign axi_rsp_o.arready      = ~rvalid_q;
  assign axi_rsp_o.rvalid       = rvalid_q;
  assign axi_rsp_o.rdata        = rdata_q;
  assign axi_rsp_o.rresp        = rresp_q;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  sequence s_wait_to_hold;
    state_q == ST_INT_WAIT ##1 state_q == ST_HOLD_LOW;
  endsequence

  AST_INT_CLOCK: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (state_q == ST_INT_COUNT || state_q == ST_INT_WAIT) && !wake_i
    |=> sys_clk_o == $past(intosc_i))
    else $error("system clock not following internal oscillator");

  AST_COUNT_DONE: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (state_q == ST_INT_COUNT) ##1 (state_q == ST_INT_WAIT)
    |-> $past(count_q) == CNT_LAST && $past(xtal_rise))
    else $error("settle count left early");

  AST_SETTLE_EDGE: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    $rose(settle_q) |-> $past(int_fall) && $past(state_q) == ST_INT_WAIT)
    else $error("status set off an internal falling edge");

  AST_SETTLE_SEQ: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    s_wait_to_hold |-> settle_q && ev_settle == 1'b0)
    else $error("hold entered without status");

  AST_HOLD_LOW: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    state_q == ST_HOLD_LOW |-> !sys_clk_o)
    else $error("system clock high during hold");

  AST_EXT_CLOCK: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    state_q == ST_EXTERNAL && !wake_i |=> sys_clk_o == $past(xtal_i))
    else $error("system clock not following crystal");

  AST_STATUS_STATE: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    settle_q == (state_q == ST_HOLD_LOW || state_q == ST_EXTERNAL))
    else $error("status bit disagrees with clock source");

  AST_WAKE_RESTART: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    wake_i |=> state_q == ST_INT_COUNT && count_q == '0 && !settle_q)
    else $error("wake did not restart the sequence");

endmodule

//--- two_speed_clock_startup_regs.svh
// Register map, field positions, reset values and counts of the start-up sequencer
// Overview of operation
// - Wake: run from internal oscillator, selected frequency
// - Count 1024 crystal cycles before any switch
// - After timeout, await internal falling edge, set status
// - Hold system clock low until crystal falling edge
// - Then drive system clock from crystal
// - Status bit readable, shows external or internal
`ifndef TWO_SPEED_CLOCK_STARTUP_REGS_SVH
`define TWO_SPEED_CLOCK_STARTUP_REGS_SVH

// ----------------------------------------------------------------------
// Offsets
// ----------------------------------------------------------------------
`define OFF_OSC_CONTROL   8'h00
`define OFF_OSC_STATUS    8'h04
`define OFF_IRQ_STATUS    8'h08
`define OFF_IRQ_MASK      8'h0C

// ----------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------
`define FREQ_SEL_W        4
`define FREQ_SEL_RST      4'h0
`define STAT_SETTLE_BIT   0
`define STAT_EXT_BIT      1
`define STAT_XTAL_CFG_BIT 2
`define IRQ_W             2
`define IRQ_SETTLE_BIT    0
`define IRQ_SWITCH_BIT    1
`define IRQ_MASK_RST      2'h0
`define SRC_SEL_W         3
`define SRC_LOW_POWER     3'h0
`define SRC_CRYSTAL       3'h1
`define SRC_HIGH_SPEED    3'h2

// ----------------------------------------------------------------------
// Bus answers and timing
// ----------------------------------------------------------------------
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2
`define SETTLE_CYCLES     1024

`endif

//--- two_speed_clock_startup_pkg.sv
// Types shared by the start-up sequencer and its bus
package two_speed_clock_startup_pkg;

  typedef enum logic [1:0] {
    ST_INT_COUNT,
    ST_INT_WAIT,
    ST_HOLD_LOW,
    ST_EXTERNAL
  } seq_state_e;

  typedef struct packed {
    logic        awvalid;
    logic [31:0] awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [31:0] araddr;
    logic        rready;
  } axi_req_s;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axi_rsp_s;

endpackage

//--- xtal_osc_model.sv
// Behavioural crystal oscillator feeding the start-up sequencer
`timescale 1ns/1ns
module xtal_osc_model (
  // Clock and reset
  input  wire logic       ref_clk_i,
  input  wire logic       rst_n_i,
  // Control
  input  wire logic       run_i,
  input  wire logic [7:0] half_i,
  // Oscillator level
  output logic            xtal_o
);
  logic [7:0] cnt_q;
  // Stands still low while stopped, as a crystal not yet swinging
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q  <= 8'h00;
      xtal_o <= 1'b0;
    end else if (!run_i) begin
      cnt_q  <= 8'h00;
      xtal_o <= 1'b0;
    end else if (cnt_q + 8'h01 >= half_i) begin
      cnt_q  <= 8'h00;
      xtal_o <= ~xtal_o;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
endmodule

//--- two_speed_clock_startup_tb.sv
// Testbench of the two-speed start-up sequencer
`timescale 1ns/1ns
`include "two_speed_clock_startup_regs.svh"
module two_speed_clock_startup_tb;
  import two_speed_clock_startup_pkg::*;
  localparam int SETTLE = 4;
  logic ref_clk, rst_n, intosc, xtal, wake, sys_clk, irq, xrun, xp, idiv;
  logic [2:0]  mode;
  logic [3:0]  fsel;
  logic [7:0]  xhalf;
  logic [31:0] d;
  logic [1:0]  r;
  axi_req_s    req;
  axi_rsp_s    rsp;
  int failures, cmp_count, rises, s, x, i, n;
  // ----------------------------------------------------------------
  // Design, partner and stimulus
  // ----------------------------------------------------------------
  two_speed_clock_startup #(.SETTLE_CYCLES(SETTLE)) DUT (.ref_clk_i(ref_clk), .rst_n_i(rst_n),
    .intosc_i(intosc), .xtal_i(xtal), .osc_source_select_i(mode), .wake_i(wake),
    .sys_clk_o(sys_clk), .internal_freq_select_o(fsel), .axi_req_i(req),
    .axi_rsp_o(rsp), .irq_o(irq));
  xtal_osc_model xosc (.ref_clk_i(ref_clk), .rst_n_i(rst_n), .run_i(xrun),
    .half_i(xhalf), .xtal_o(xtal));
  always #50 ref_clk = ~ref_clk;
  // Internal oscillator at a quarter of the reference rate
  always @(posedge ref_clk) begin
    idiv <= ~idiv;
    if (idiv) intosc <= ~intosc;
  end
  always @(posedge ref_clk) begin
    xp <= xtal;
    if (wake) rises <= 0;
    else if (xtal && !xp) rises <= rises + 1;
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] dat);
    logic ta, tw, tb;
    int k;
    @(posedge ref_clk);
    req.awvalid <= 1'b1; req.awaddr <= {24'h00_0000, a}; req.wvalid <= 1'b1;
    req.wdata <= dat; req.wstrb <= 4'hF; req.bready <= 1'b1;
    for (k = 0; k < 64; k++) begin
      @(negedge ref_clk);
      ta = req.awvalid & rsp.awready; tw = req.wvalid & rsp.wready; tb = rsp.bvalid;
      r = rsp.bresp;
      @(posedge ref_clk);
      if (ta) req.awvalid <= 1'b0;
      if (tw) req.wvalid <= 1'b0;
      if (tb) begin
        req.bready <= 1'b0;
        break;
      end
    end
    if (k == 64) begin failures++; end_sim(); end
  endtask
  task automatic rd(input logic [7:0] a);
    logic ta, tr;
    int k;
    @(posedge ref_clk);
    req.arvalid <= 1'b1; req.araddr <= {24'h00_0000, a}; req.rready <= 1'b1;
    for (k = 0; k < 64; k++) begin
      @(negedge ref_clk);
      ta = req.arvalid & rsp.arready; tr = rsp.rvalid; d = rsp.rdata; r = rsp.rresp;
      @(posedge ref_clk);
      if (ta) req.arvalid <= 1'b0;
      if (tr) begin
        req.rready <= 1'b0;
        break;
      end
    end
    if (k == 64) begin failures++; end_sim(); end
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    rd(a);
    chk(d, exp);
  endtask
  task automatic pulse();
    @(posedge ref_clk) wake <= 1'b1;
    @(posedge ref_clk) wake <= 1'b0;
    repeat (2) @(posedge ref_clk);
  endtask
  // Rising edges of each clock over 32 reference cycles
  task automatic count();
    logic ps, px, pi;
    s = 0; x = 0; i = 0; ps = sys_clk; px = xtal; pi = intosc;
    repeat (32) begin
      @(negedge ref_clk);
      s += int'(sys_clk & !ps); x += int'(xtal & !px); i += int'(intosc & !pi);
      ps = sys_clk; px = xtal; pi = intosc;
    end
  endtask
  initial begin
    ref_clk = 0; rst_n = 0; intosc = 0; wake = 0; xrun = 0; xhalf = 8'h08; mode = 3'h1;
    req = '0; failures = 0; cmp_count = 0; rises = 0; idiv = 0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    count();
    chk(32'(s > i - 2 && s < i + 2 && i > 4), 32'h1);
    wr(`OFF_OSC_CONTROL, 32'h0000_000A);
    chk(32'(fsel), 32'h0000_000A);
    chk(32'(r), 32'h0000_0000);
    rd_chk(`OFF_OSC_CONTROL, 32'h0000_000A);
    rd_chk(8'h10, 32'h0000_0000);
    chk(32'(r), 32'h0000_0002);
    wr(8'h10, 32'hFFFF_FFFF);
    chk(32'(r), 32'h0000_0002);
    wr(`OFF_IRQ_MASK, 32'h0000_0003);
    for (int b = 0; b < 4; b++) begin
      mode <= (b == 3) ? 3'h7 : 3'(b);
      pulse();
      rd_chk(`OFF_OSC_STATUS, (b == 3) ? 32'h0 : 32'h0000_0004);
    end
    mode <= 3'h2; xrun <= 1'b1;
    pulse();
    for (n = 0; n < 400 && irq !== 1'b1; n++) @(negedge ref_clk);
    if (n == 400) begin failures++; end_sim(); end
    chk(32'(rises == SETTLE), 32'h1);
    // Low until the crystal has fallen and risen again
    for (n = 0; n < 40 && !(xp && !xtal); n++) begin
      @(negedge ref_clk);
      chk(32'(sys_clk), 32'h0);
    end
    if (n == 40) begin failures++; end_sim(); end
    for (n = 0; n < 40 && !xtal; n++) begin
      @(negedge ref_clk);
      chk(32'(sys_clk), 32'h0);
    end
    if (n == 40) begin failures++; end_sim(); end
    count();
    chk(32'(s > x - 2 && s < x + 2 && x > 0), 32'h1);
    rd_chk(`OFF_OSC_STATUS, 32'h0000_0007);
    rd_chk(`OFF_IRQ_STATUS, 32'h0000_0003);
    wr(`OFF_IRQ_STATUS, 32'h0000_0003);
    rd_chk(`OFF_IRQ_STATUS, 32'h0000_0000);
    chk(32'(irq), 32'h0);
    pulse();
    rd_chk(`OFF_OSC_STATUS, 32'h0000_0004);
    // Settle again, then a power-on reset in mid-run must start over
    for (n = 0; n < 400 && irq !== 1'b1; n++) @(negedge ref_clk);
    if (n == 400) begin failures++; end_sim(); end
    @(posedge ref_clk) rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    chk(32'(irq), 32'h0);
    chk(32'(fsel), 32'h0000_0000);
    rd_chk(`OFF_OSC_STATUS, 32'h0000_0004);
    count();
    chk(32'(s > i - 2 && s < i + 2 && i > 4), 32'h1);
    end_sim();
  end
endmodule
